// ---- src/alert_cfg_params.svh ----
`ifndef ALERT_CFG_PARAMS_SVH
`define ALERT_CFG_PARAMS_SVH
// register addresses (command codes)
`define ADDR_OPT_ZERO 8'h33
`define ADDR_OPT_ONE 8'h34
// reset values
`define RST_OPT_ZERO_MULTI 16'h4a81
`define RST_OPT_ZERO_SINGLE 16'h4a09
`define RST_OPT_ONE 16'h41a0
// field positions, option zero
`define VTH_HI 7
`define VTH_LO 2
`define NOMINAL_CURRENT_DEGLITCH_BIT 1
`define LOWER_SEL_BIT 0
`define RATIO_BIT 8
// field positions, option one
`define DTH_HI 15
`define DTH_LO 10
`define DDEG_HI 9
`define DDEG_LO 8
`define PP_VIN 7
`define PROFILE_COMPARATOR 6
`define PROFILE_CRITICAL_CURRENT 5
`define PP_NOMINAL_INPUT_CURRENT_EVENT 4
`define PP_DCHG1 3
`define PP_SYSTEM_VOLTAGE 2
// decoding units
`define SYSTEM_VOLTAGE_BASE_MV 16'd3200
`define SYSTEM_VOLTAGE_STEP_MV 16'd100
`define DCHG_STEP_MA 16'd512
// timing: clock 250 MHz
`define CLK_MHZ 250
`define SYSTEM_VOLTAGE_DEG_NS 5000
`define SYSTEM_VOLTAGE_DEG_CYC ((`SYSTEM_VOLTAGE_DEG_NS * `CLK_MHZ) / 1000)
`define NOMINAL_INPUT_CURRENT_EVENT_DEG0_MS 1
`define NOMINAL_INPUT_CURRENT_EVENT_DEG1_MS 60
`define DDEG0_MS 78
`define DDEG1_MS 1250
`define DDEG2_MS 5000
`define DDEG3_MS 20000
`define CYC_PER_MS (`CLK_MHZ * 1000)
// comparator ratios, percent of the programmed setting
`define RATIO_LO_PCT 8'd83
`define RATIO_HI_PCT 8'd91
`define NOMINAL_INPUT_CURRENT_EVENT_PCT 8'd110
// last count of the cell strap wait, so the synchroniser has settled first
`define STRAP_WAIT_END 2'h3
`endif

// ---- src/alert_cfg_pkg.sv ----
package alert_cfg_pkg;
  typedef logic [15:0] reg16_t;
  typedef logic [33:0] count_t;
endpackage

// ---- src/deglitch_timer.sv ----
// Purpose: persistence filter; output rises after input held for limit cycles
// Assumes: input already synchronised to i_clk
// Notes: count restarts whenever the condition drops
`timescale 1ns/10ps
module deglitch_timer
  import alert_cfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_cond,
  input wire count_t i_limit,
  output logic o_event
);
  count_t cnt;
  count_t next_cnt;
  logic next_event;

  always_comb begin
    next_cnt = cnt;
    next_event = 1'b0;
    if (!i_cond) begin
      next_cnt = '0;
    end else if (cnt + 34'h1 >= i_limit) begin
      next_cnt = i_limit;
      next_event = 1'b1;
    end else begin
      next_cnt = cnt + 34'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt <= '0;
      o_event <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_event <= next_event;
    end
  end
endmodule

// ---- src/processor_hot_profile_config.sv ----
// Purpose: processor-hot threshold and profile registers with event gating
// Assumes: comparator inputs are asynchronous pins; host bus decoded outside
// Notes: long deglitch counts are parameters so simulation can shorten them
`timescale 1ns/10ps
`include "alert_cfg_params.svh"
module processor_hot_profile_config
  import alert_cfg_pkg::*;
#(
  parameter count_t NOMINAL_INPUT_CURRENT_EVENT_DEG0_CYC = count_t'(`NOMINAL_INPUT_CURRENT_EVENT_DEG0_MS * `CYC_PER_MS),
  parameter count_t NOMINAL_INPUT_CURRENT_EVENT_DEG1_CYC = count_t'(`NOMINAL_INPUT_CURRENT_EVENT_DEG1_MS * `CYC_PER_MS),
  parameter count_t DDEG0_CYC = count_t'(64'(`DDEG0_MS) * `CYC_PER_MS),
  parameter count_t DDEG1_CYC = count_t'(64'(`DDEG1_MS) * `CYC_PER_MS),
  parameter count_t DDEG2_CYC = count_t'(64'(`DDEG2_MS) * `CYC_PER_MS),
  parameter count_t DDEG3_CYC = count_t'(64'(`DDEG3_MS) * `CYC_PER_MS)
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_single_cell,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] i_input_current_limit_setting,
  input wire logic [15:0] i_input_current_ma,
  input wire logic [15:0] i_discharge_current_ma,
  input wire logic [15:0] i_system_voltage_mv,
  input wire logic [15:0] i_input_voltage_regulation_mv,
  input wire logic [15:0] i_input_bus_voltage_mv,
  input wire logic i_critical_current_event,
  input wire logic i_comparator_trip,
  input wire logic i_low_power_mode,
  input wire logic i_low_power_alert_enable,
  output logic [15:0] o_rdata,
  output logic [15:0] o_opt_zero,
  output logic [15:0] o_opt_one,
  output logic [15:0] o_sys_voltage_threshold_mv,
  output logic [15:0] o_discharge_threshold_ma,
  output logic [15:0] o_vin_comparator_threshold_mv,
  output logic o_bus_discharge_request,
  output logic [7:0] o_status,
  output logic o_processor_hot_alert_n
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [4:0] meta;
  logic [4:0] sync;
  logic strap_done;
  logic next_strap_done;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= {i_critical_current_event, i_comparator_trip, i_low_power_mode,
               i_low_power_alert_enable, i_single_cell};
      sync <= meta;
    end
  end
  wire logic s_single = sync[0];
  wire logic s_lp_en = sync[1];
  wire logic s_lp_mode = sync[2];
  wire logic s_comp = sync[3];
  wire logic s_crit = sync[4];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg16_t next_opt_zero;
  reg16_t next_opt_one;
  reg16_t next_rdata;

  always_comb begin
    next_opt_zero = o_opt_zero;
    next_opt_one = o_opt_one;
    next_strap_done = 1'b1;
    if (!strap_done) begin
      // cell strap caught once the synchroniser has settled after reset
      next_opt_zero = s_single ? `RST_OPT_ZERO_SINGLE : `RST_OPT_ZERO_MULTI;
    end else if (i_wr && i_addr == `ADDR_OPT_ZERO) begin
      next_opt_zero = i_wdata;
    end
    if (i_wr && i_addr == `ADDR_OPT_ONE) begin
      next_opt_one = i_wdata;
    end
    unique case (i_addr)
      `ADDR_OPT_ZERO: next_rdata = o_opt_zero;
      `ADDR_OPT_ONE: next_rdata = o_opt_one;
      default: next_rdata = 16'h0000;
    endcase
  end

  logic [1:0] strap_wait;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_opt_zero <= `RST_OPT_ZERO_MULTI;
      o_opt_one <= `RST_OPT_ONE;
      o_rdata <= 16'h0000;
      strap_wait <= 2'h0;
      strap_done <= 1'b0;
    end else begin
      o_opt_zero <= next_opt_zero;
      o_opt_one <= next_opt_one;
      o_rdata <= next_rdata;
      strap_wait <= (strap_wait == `STRAP_WAIT_END) ? strap_wait : strap_wait + 2'h1;
      strap_done <= (strap_wait == `STRAP_WAIT_END) ? next_strap_done : 1'b0;
    end
  end

  // ------------------------------------------------------------
  // threshold decode
  // ------------------------------------------------------------
  function automatic logic [15:0] system_voltage_mv(input logic [5:0] code, input logic single);
    logic [5:0] c;
    c = single ? {3'h0, code[2:0]} : code;
    system_voltage_mv = `SYSTEM_VOLTAGE_BASE_MV + 16'(c) * `SYSTEM_VOLTAGE_STEP_MV;
  endfunction

  // percentage of a value, truncated
  function automatic logic [15:0] pct(input logic [15:0] v, input logic [7:0] p);
    logic [23:0] prod;
    prod = 24'(v) * 24'(p);
    pct = 16'(prod / 24'd100);
  endfunction

  wire logic [5:0] vth_code = o_opt_zero[`VTH_HI:`VTH_LO];
  wire logic [5:0] dth_code = o_opt_one[`DTH_HI:`DTH_LO];
  wire logic [15:0] system_voltage_th = system_voltage_mv(vth_code, s_single);
  wire logic [15:0] dchg_th = 16'(dth_code) * `DCHG_STEP_MA;
  logic [15:0] vin_th;
  always_comb begin
    if (!o_opt_zero[`LOWER_SEL_BIT]) begin
      vin_th = i_input_voltage_regulation_mv;
    end else begin
      vin_th = pct(i_input_voltage_regulation_mv,
                   o_opt_zero[`RATIO_BIT] ? `RATIO_HI_PCT : `RATIO_LO_PCT);
    end
  end
  wire logic [15:0] nominal_input_current_event_th = pct(i_input_current_limit_setting, `NOMINAL_INPUT_CURRENT_EVENT_PCT);

  // ------------------------------------------------------------
  // deglitched events
  // ------------------------------------------------------------
  count_t nominal_input_current_event_lim;
  count_t ddeg_lim;
  always_comb begin
    nominal_input_current_event_lim = o_opt_zero[`NOMINAL_CURRENT_DEGLITCH_BIT] ? NOMINAL_INPUT_CURRENT_EVENT_DEG1_CYC : NOMINAL_INPUT_CURRENT_EVENT_DEG0_CYC;
    unique case (o_opt_one[`DDEG_HI:`DDEG_LO])
      2'h0: ddeg_lim = DDEG0_CYC;
      2'h1: ddeg_lim = DDEG1_CYC;
      2'h2: ddeg_lim = DDEG2_CYC;
      2'h3: ddeg_lim = DDEG3_CYC;
    endcase
  end

  logic ev_system_voltage;
  logic ev_nominal_input_current_event;
  logic ev_dchg;
  deglitch_timer u_system_voltage (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_cond(i_system_voltage_mv < system_voltage_th),
    .i_limit(count_t'(`SYSTEM_VOLTAGE_DEG_CYC)),
    .o_event(ev_system_voltage)
  );
  deglitch_timer u_nominal_input_current_event (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_cond(i_input_current_ma > nominal_input_current_event_th),
    .i_limit(nominal_input_current_event_lim),
    .o_event(ev_nominal_input_current_event)
  );
  deglitch_timer u_dchg (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_cond(i_discharge_current_ma > dchg_th),
    .i_limit(ddeg_lim),
    .o_event(ev_dchg)
  );

  // ------------------------------------------------------------
  // profile gating and outputs
  // ------------------------------------------------------------
  logic [7:0] raw;
  logic [7:0] next_status;
  logic comp_en;
  always_comb begin
    raw = 8'h00;
    raw[`PP_VIN] = i_input_bus_voltage_mv < vin_th;
    raw[`PROFILE_COMPARATOR] = s_comp;
    raw[`PROFILE_CRITICAL_CURRENT] = s_crit;
    raw[`PP_NOMINAL_INPUT_CURRENT_EVENT] = ev_nominal_input_current_event;
    raw[`PP_DCHG1] = ev_dchg;
    raw[`PP_SYSTEM_VOLTAGE] = ev_system_voltage;
    comp_en = s_lp_mode ? s_lp_en : o_opt_one[`PROFILE_COMPARATOR];
    next_status = raw & o_opt_one[7:0];
    next_status[`PROFILE_COMPARATOR] = raw[`PROFILE_COMPARATOR] & comp_en;
    if (o_opt_one[7:0] == 8'h00) begin
      next_status = 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_status <= 8'h00;
      o_processor_hot_alert_n <= 1'b1;
      o_bus_discharge_request <= 1'b0;
      o_sys_voltage_threshold_mv <= 16'h0000;
      o_discharge_threshold_ma <= 16'h0000;
      o_vin_comparator_threshold_mv <= 16'h0000;
    end else begin
      o_status <= next_status;
      o_processor_hot_alert_n <= ~|next_status;
      o_bus_discharge_request <= ev_system_voltage;
      o_sys_voltage_threshold_mv <= system_voltage_th;
      o_discharge_threshold_ma <= dchg_th;
      o_vin_comparator_threshold_mv <= vin_th;
    end
  end
endmodule

// ---- verification/processor_hot_profile_config_checker.sv ----
// Purpose: port checks for the alert config block
// Assumes: sync active-low reset
// Notes: decode check waits for a settled register
`timescale 1ns/10ps
`include "alert_cfg_params.svh"
module processor_hot_profile_config_checker (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] o_rdata,
  input wire logic [15:0] o_opt_zero,
  input wire logic [15:0] o_opt_one,
  input wire logic [15:0] o_discharge_threshold_ma,
  input wire logic [7:0] o_status,
  input wire logic o_processor_hot_alert_n
);
  // ---------------------------------------------
  // settle tracking
  // ---------------------------------------------
  logic [15:0] prev, next_prev;
  logic [1:0] calm, next_calm;
  always_comb begin
    next_prev = o_opt_one;
    next_calm = (o_opt_one != prev) ? 2'h0 : (calm == 2'h3) ? calm : calm + 2'h1;
  end
  always_ff @(posedge i_clk) begin
    prev <= next_prev;
    calm <= i_nrst ? next_calm : 2'h0;
  end
  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  chk_wr_one: assert property (
    i_wr && i_addr == `ADDR_OPT_ONE |=> o_opt_one == $past(i_wdata)) else $error("write lost");
  chk_stray_wr: assert property (
    i_wr && i_addr != `ADDR_OPT_ZERO && i_addr != `ADDR_OPT_ONE |=> $stable(o_opt_one))
    else $error("stray write taken");
  chk_rd_one: assert property (
    $past(i_nrst) && $past(i_addr) == `ADDR_OPT_ONE |-> o_rdata == $past(o_opt_one))
    else $error("read data wrong");
  chk_rd_none: assert property (
    $past(i_nrst) && $past(i_addr) > `ADDR_OPT_ONE |-> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_dis_decode: assert property (
    calm == 2'h3 && o_opt_one == prev |-> o_discharge_threshold_ma == {1'b0, prev[15:10], 9'h000})
    else $error("discharge decode wrong");
  chk_gate_status: assert property (
    (o_status & ~$past(o_opt_one[7:0]) & 8'hbf) == 8'h00) else $error("ungated status");
  chk_low_bits: assert property (o_status[1:0] == 2'b00)
    else $error("status low bits set");
  chk_all_off: assert property (
    o_opt_one[7:0] == 8'h00 |=> o_processor_hot_alert_n) else $error("alert while disabled");
endmodule
bind processor_hot_profile_config processor_hot_profile_config_checker i_chk (.i_clk(i_clk),
  .i_nrst(i_nrst), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .o_opt_zero(o_opt_zero), .o_opt_one(o_opt_one), .o_status(o_status),
  .o_discharge_threshold_ma(o_discharge_threshold_ma),
  .o_processor_hot_alert_n(o_processor_hot_alert_n));

// ---- verification/host_model.sv ----
// Purpose: host side of the register port
// Assumes: driven off the falling edge
// Notes: idle data is inverted so stale values are never relied on
`timescale 1ns/10ps
module host_model (
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [15:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_addr = 8'h00;
    o_wdata = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clk);
    {o_wr, o_addr, o_wdata} = {1'b1, a, d};
    @(negedge i_clk);
    {o_wr, o_wdata} = {1'b0, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge i_clk);
    o_addr = a;
    @(negedge i_clk);
    d = i_rdata;
  endtask
endmodule

// ---- verification/processor_hot_profile_config_tb.sv ----
// Purpose: self-checking bench for the alert config block
// Assumes: shortened current deglitch counts, full system-voltage filter
// Notes: event latency is accepted within a three-cycle window
`timescale 1ns/10ps
module processor_hot_profile_config_tb;
  logic i_clk = 1'b0, i_nrst = 1'b0, sc = 1'b0, crit = 1'b0, cmp = 1'b0, lpm = 1'b0, lpe = 1'b0;
  logic [15:0] ic = 16'h0000, dc = 16'h0000, vs = 16'h7fff, vr = 16'h1388, z, o, v;
  logic [15:0] il = 16'h03e8, vb = 16'h7fff;
  localparam logic [33:0] DG0 = 34'ha, DG1 = 34'h14, DG2 = 34'h1e;
  localparam logic [33:0] DG3 = 34'h28, DG4 = 34'h32, DG5 = 34'h3c;
  logic wr, req, an;
  logic [7:0] ad, st;
  logic [15:0] wd, rdv, oz, oo, vth, dth, cth;
  int err_count = 0, checked = 0, cyc = 0, n;
  initial forever #2 i_clk = ~i_clk;
  host_model i_host (.i_clk(i_clk), .i_rdata(rdv), .o_wr(wr), .o_addr(ad), .o_wdata(wd));
  processor_hot_profile_config #(.NOMINAL_INPUT_CURRENT_EVENT_DEG0_CYC(DG0), .NOMINAL_INPUT_CURRENT_EVENT_DEG1_CYC(DG1),
    .DDEG0_CYC(DG2), .DDEG1_CYC(DG3), .DDEG2_CYC(DG4), .DDEG3_CYC(DG5)) i_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_single_cell(sc), .i_wr(wr), .i_addr(ad), .i_wdata(wd),
    .i_input_current_limit_setting(il), .i_input_current_ma(ic),
    .i_discharge_current_ma(dc), .i_system_voltage_mv(vs), .i_input_voltage_regulation_mv(vr),
    .i_input_bus_voltage_mv(vb), .i_critical_current_event(crit), .i_comparator_trip(cmp),
    .i_low_power_mode(lpm), .i_low_power_alert_enable(lpe), .o_rdata(rdv), .o_opt_zero(oz),
    .o_opt_one(oo), .o_sys_voltage_threshold_mv(vth), .o_discharge_threshold_ma(dth),
    .o_vin_comparator_threshold_mv(cth), .o_bus_discharge_request(req), .o_status(st),
    .o_processor_hot_alert_n(an));
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic rst(input logic s);
    {sc, i_nrst} = {s, 1'b0};
    repeat (8) @(negedge i_clk);
    i_nrst = 1'b1;
    repeat (10) @(negedge i_clk);
  endtask
  task automatic meas(input int b, input int lo, input string s);
    n = 0;
    while (st[b] !== 1'b1 && n < 1400) begin
      @(negedge i_clk);
      n++;
    end
    chk(s, 16'h0001, {15'h0, n > lo && n < lo + 4});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [15:0] vexp(input logic [15:0] x, input logic s);
    return 16'h0c80 + 16'h0064 * (s ? 16'(x[4:2]) : 16'(x[7:2]));
  endfunction
  function automatic logic [15:0] cexp(input logic [15:0] x, input logic [15:0] r);
    return x[0] ? 16'((32'(r) * (x[8] ? 32'h5b : 32'h53)) / 32'h64) : r;
  endfunction
  function automatic logic [15:0] pexp(input logic [15:0] r, input logic [7:0] p);
    return 16'((32'(r) * 32'(p)) / 32'h64);
  endfunction
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      $display("[ERR] run exp end got hang");
      wrap_up();
    end
  end
  initial begin
    void'($urandom(41198));
    rst(1'b0);
    chk("zero", 16'h4a81, oz);
    chk("one", 16'h41a0, oo);
    $display("reset test done");
    for (int i = 0; i < 18; i++) begin
      z = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
      {o, vr} = {i == 0 ? 16'hffff : 16'($urandom), 16'($urandom)};
      i_host.wr(8'h33, z);
      i_host.wr(8'h34, o);
      i_host.wr(8'h35, ~z);
      i_host.rd(8'h33, v);
      chk("rd zero", z, v);
      i_host.rd(8'h34, v);
      chk("rd one", o, v);
      i_host.rd(8'h35, v);
      chk("rd none", 16'h0000, v);
      chk("sys th", vexp(z, 1'b0), vth);
      chk("dis th", {1'b0, o[15:10], 9'h000}, dth);
      chk("cmp th", cexp(z, vr), cth);
    end
    $display("register test done");
    for (int k = 0; k < 6; k++) begin
      il = k[0] ? 16'h07d0 : 16'h03e8;
      i_host.wr(8'h34, 16'h0000);
      i_host.wr(8'h33, {14'h0, k[0], 1'b1});
      // the dip to the exact threshold must restart the count
      i_host.wr(8'h34, k < 4 ? {6'h02, 2'(k), 8'h08} : 16'h0010);
      {dc, ic} = {16'h0401, pexp(il, 8'h6e)};
      repeat (28) @(negedge i_clk);
      dc = 16'h0400;
      @(negedge i_clk);
      {dc, ic} = {16'h0401, pexp(il, 8'h6e) + 16'h0001};
      if (k < 4) meas(3, 30 + 10 * k, "dchg");
      else meas(4, 10 + 10 * k[0], "nominal_input_current_event");
      chk("alert", 16'h0000, {15'h0, an});
      {dc, ic} = 32'h0;
    end
    $display("event test done");
    {crit, cmp} = 2'b11;
    i_host.wr(8'h34, 16'h0000);
    repeat (20) @(negedge i_clk);
    chk("off", 16'h0100, {7'h0, an, st});
    i_host.wr(8'h34, 16'h0040);
    repeat (8) @(negedge i_clk);
    chk("comp", 16'h0040, {8'h0, st});
    lpm = 1'b1;
    repeat (8) @(negedge i_clk);
    chk("lp comp", 16'h0000, {8'h0, st});
    lpe = 1'b1;
    i_host.wr(8'h34, 16'h0020);
    repeat (8) @(negedge i_clk);
    chk("lp en", 16'h0060, {7'h0, an, st});
    {crit, cmp, lpm, lpe, vr} = {4'h0, 16'h1388};
    i_host.wr(8'h33, 16'h0101);
    i_host.wr(8'h34, 16'h0080);
    vb = 16'h11c5;
    repeat (4) @(negedge i_clk);
    chk("vin 91", 16'h0080, {7'h0, an, st});
    chk("cmp 91", pexp(vr, 8'h5b), cth);
    vb = 16'h11c6;
    repeat (4) @(negedge i_clk);
    chk("vin edge", 16'h0100, {7'h0, an, st});
    i_host.wr(8'h33, 16'h0100);
    repeat (4) @(negedge i_clk);
    chk("vin reg", 16'h0080, {7'h0, an, st});
    vb = 16'h7fff;
    $display("gating test done");
    i_host.wr(8'h33, 16'h0041);
    i_host.wr(8'h34, 16'h0004);
    vs = 16'h12bf;
    meas(2, 1250, "system_voltage");
    chk("bus req", 16'h0001, {15'h0, req});
    vs = 16'h7fff;
    rst(1'b1);
    chk("zero 1s", 16'h4a09, oz);
    chk("th 1s", 16'h0d48, vth);
    i_host.wr(8'h33, 16'h00fd);
    repeat (4) @(negedge i_clk);
    chk("th 1s", vexp(16'h00fd, 1'b1), vth);
    $display("cell test done");
    wrap_up();
  end
endmodule
